// >>> src/scfg_host.sv
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ns
`default_nettype none
module scfg_host
    import scfg_pkg::*;
#(
    parameter int SCLK_HALF = SCLK_HALF_DEF // clk per half
) (
    input  wire logic                  clk,     // System clock
    input  wire logic                  rst,     // Async reset
    input  wire logic [AXI_ADDR_W-1:0] awaddr,  // Write address
    input  wire logic                  awvalid, // Address valid
    output logic                       awready, // Address taken
    input  wire logic [31:0]           wdata,   // Write data
    input  wire logic [3:0]            wstrb,   // Byte enables
    input  wire logic                  wvalid,  // Data valid
    output logic                       wready,  // Data taken
    output logic [1:0]                 bresp,   // Write answer
    output logic                       bvalid,  // Answer valid
    input  wire logic                  bready,  // Answer taken
    input  wire logic [AXI_ADDR_W-1:0] araddr,  // Read address
    input  wire logic                  arvalid, // Address valid
    output logic                       arready, // Address taken
    output logic [31:0]                rdata,   // Read data
    output logic [1:0]                 rresp,   // Read answer
    output logic                       rvalid,  // Answer valid
    input  wire logic                  rready,  // Answer taken
    scfg_if.host                       link     // Serial pins
);
    localparam logic [7:0] HALF_END = 8'(SCLK_HALF - 1);

    // Bus slave state
    logic                  awready_ff, wready_ff, bvalid_ff;
    logic                  arready_ff, rvalid_ff;
    logic [1:0]            bresp_ff, rresp_ff;
    logic [31:0]           rdata_ff, wd_ff;
    logic [3:0]            ws_ff;
    logic [AXI_ADDR_W-1:0] wa_ff;
    logic                  aw_held_ff, w_held_ff;
    // Host registers and sequencer
    logic [DATA_W-1:0]     wdat_ff, rdat_ff, rx_ff;
    logic [CMD_W-1:0]      cmd_ff;
    logic [TX_W-1:0]       tx_ff;
    logic [4:0]            bit_ff;
    logic [7:0]            div_ff;
    logic                  sclk_ff, fen_n_ff, sdo_ff, oe_ff;
    scfg_state_t           state_ff;
    logic [1:0]            pins;    // Synced sdio, sdo

    // Returning data is asynchronous to clk
    scfg_sync #(.WIDTH(2)) u_sync (
        .clk (clk),
        .rst (rst),
        .d   ({link.serial_data_output, link.sdio}),
        .q   (pins)
    );

    // Decode
    wire do_wr   = aw_held_ff & w_held_ff & ~bvalid_ff;
    wire wr_wdat = do_wr & (wa_ff == OFS_WDATA);
    wire wr_cmd  = do_wr & (wa_ff == OFS_CMD);
    wire wr_ok   = wr_wdat | wr_cmd | (wa_ff == OFS_STATUS)
                 | (wa_ff == OFS_RDATA);
    wire idle    = (state_ff == SCFG_IDLE);
    wire start   = wr_cmd & ws_ff[0] & idle;
    wire sel_wd  = (araddr == OFS_WDATA);
    wire sel_cm  = (araddr == OFS_CMD);
    wire sel_st  = (araddr == OFS_STATUS);
    wire sel_rd  = (araddr == OFS_RDATA);
    wire rd_ok   = sel_wd | sel_cm | sel_st | sel_rd;
    wire [31:0] rd_val = sel_wd ? {16'h0, wdat_ff}
                       : sel_cm ? {23'h0, cmd_ff}
                       : sel_st ? {31'h0, ~idle}
                       : sel_rd ? {16'h0, rdat_ff} : 32'h0;
    wire tick    = (div_ff == HALF_END);
    wire rise    = ~idle & ~(state_ff == SCFG_CLOSE) & tick
                 & ~sclk_ff;
    wire fall    = (state_ff == SCFG_SHIFT) & tick & sclk_ff;
    wire rd_fr   = cmd_ff[RW_POS];
    wire rx_pin  = cmd_ff[CMD_MODE_POS] ? pins[1] : pins[0];
    wire [4:0] nxt_bit = bit_ff + 5'h01;

    // Write channel: address and data in either order
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            awready_ff <= 1'h1;
            wready_ff  <= 1'h1;
            aw_held_ff <= 1'h0;
            w_held_ff  <= 1'h0;
            bvalid_ff  <= 1'h0;
            bresp_ff   <= RESP_OKAY;
            wa_ff      <= '0;
            wd_ff      <= 32'h0;
            ws_ff      <= 4'h0;
        end
        else
        begin
            if (awvalid & awready_ff)
            begin
                wa_ff      <= awaddr;
                aw_held_ff <= 1'h1;
                awready_ff <= 1'h0;
            end
            if (wvalid & wready_ff)
            begin
                wd_ff     <= wdata;
                ws_ff     <= wstrb;
                w_held_ff <= 1'h1;
                wready_ff <= 1'h0;
            end
            if (do_wr)
            begin
                // Unmapped offsets answer with an error
                bresp_ff   <= wr_ok ? RESP_OKAY : RESP_SLVERR;
                bvalid_ff  <= 1'h1;
                aw_held_ff <= 1'h0;
                w_held_ff  <= 1'h0;
            end
            if (bvalid_ff & bready)
            begin
                bvalid_ff  <= 1'h0;
                awready_ff <= 1'h1;
                wready_ff  <= 1'h1;
            end
        end
    end

    // Read channel: answer one cycle after address
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            arready_ff <= 1'h1;
            rvalid_ff  <= 1'h0;
            rdata_ff   <= 32'h0;
            rresp_ff   <= RESP_OKAY;
        end
        else if (arvalid & arready_ff)
        begin
            rdata_ff   <= rd_val;
            rresp_ff   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            rvalid_ff  <= 1'h1;
            arready_ff <= 1'h0;
        end
        else if (rvalid_ff & rready)
        begin
            rvalid_ff  <= 1'h0;
            arready_ff <= 1'h1;
        end
    end

    // Software registers; wdata byte lanes honoured, cmd loads all 9 bits on lane 0 alone
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wdat_ff <= 16'h0;
            cmd_ff  <= '0;
        end
        else
        begin
            if (wr_wdat & ws_ff[0])
                wdat_ff[7:0] <= wd_ff[7:0];
            if (wr_wdat & ws_ff[1])
                wdat_ff[15:8] <= wd_ff[15:8];
            // A command while busy is dropped
            if (start)
                cmd_ff <= wd_ff[CMD_W-1:0];
        end
    end

    // Half-period divider making sclk
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            div_ff <= 8'h0;
        else if (idle | tick)
            div_ff <= 8'h0;
        else
            div_ff <= div_ff + 8'h01;
    end

    // frame held low for all bits
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_ff <= SCFG_IDLE;
            fen_n_ff <= 1'h1;
            sclk_ff  <= 1'h0;
            oe_ff    <= 1'h0;
            sdo_ff   <= 1'h0;
            tx_ff    <= '0;
            bit_ff   <= 5'h0;
            rx_ff    <= 16'h0;
            rdat_ff  <= 16'h0;
        end
        else
        begin
            unique case (state_ff)
                SCFG_IDLE:
                begin
                    if (start)
                    begin
                        tx_ff    <= {wd_ff[7:0], wdat_ff};
                        sdo_ff   <= wd_ff[RW_POS];
                        oe_ff    <= 1'h1;
                        fen_n_ff <= 1'h0;
                        bit_ff   <= 5'h0;
                        state_ff <= SCFG_SHIFT;
                    end
                end
                SCFG_SHIFT:
                begin
                    if (rise)
                        sclk_ff <= 1'h1;
                    if (fall)
                    begin
                        sclk_ff <= 1'h0;
                        if (rd_fr & (bit_ff >= INSTR_BITS))
                            rx_ff <= {rx_ff[DATA_W-2:0], rx_pin};
                        if (bit_ff == LAST_BIT)
                            state_ff <= SCFG_CLOSE;
                        else
                        begin
                            bit_ff <= nxt_bit;
                            tx_ff  <= {tx_ff[TX_W-2:0], 1'h0};
                            sdo_ff <= tx_ff[TX_W-2];
                            oe_ff  <= ~rd_fr | (nxt_bit < INSTR_BITS);
                        end
                    end
                end
                SCFG_CLOSE:
                begin
                    if (tick)
                    begin
                        fen_n_ff <= 1'h1;
                        oe_ff    <= 1'h0;
                        if (rd_fr)
                            rdat_ff <= rx_ff;
                        state_ff <= SCFG_IDLE;
                    end
                end
            endcase
        end
    end

    assign awready           = awready_ff;
    assign wready            = wready_ff;
    assign bvalid            = bvalid_ff;
    assign bresp             = bresp_ff;
    assign arready           = arready_ff;
    assign rvalid            = rvalid_ff;
    assign rdata             = rdata_ff;
    assign rresp             = rresp_ff;
    assign link.sclk         = sclk_ff;
    assign link.frame_enable_n = fen_n_ff;
    assign link.host_sdio_o  = sdo_ff;
    assign link.host_sdio_oe = oe_ff;
endmodule
`default_nettype wire

// >>> src/scfg_pkg.sv
package scfg_pkg;
    // Frame layout, in serial bits
    localparam logic [4:0] INSTR_BITS = 5'h08;
    localparam logic [4:0] LAST_BIT   = 5'h17;
    localparam logic [4:0] FRAME_BITS = 5'h18;
    localparam int         RW_POS     = 7;
    localparam int         DATA_W     = 16;
    localparam int         IDX_W      = 7;
    localparam int         TX_W       = 24;
    // Device register map
    localparam logic [6:0]  IDX_DATAPATH  = 7'h00;
    localparam logic [15:0] DATAPATH_RST  = 16'h049c;
    localparam logic [6:0]  IDX_PORT_MODE = 7'h02;
    localparam int          FOUR_WIRE_POS = 7;
    // Host register map, byte offsets
    localparam int         AXI_ADDR_W   = 4;
    localparam logic [3:0] OFS_WDATA    = 4'h0;
    localparam logic [3:0] OFS_CMD      = 4'h4;
    localparam logic [3:0] OFS_STATUS   = 4'h8;
    localparam logic [3:0] OFS_RDATA    = 4'hc;
    localparam int         CMD_MODE_POS = 8;
    localparam int         CMD_W        = 9;
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;
    // Host clock divider default
    localparam int         SCLK_HALF_DEF = 4;
    // Host sequencer states
    typedef enum logic [2:0] {
        SCFG_IDLE  = 3'h1,
        SCFG_SHIFT = 3'h2,
        SCFG_CLOSE = 3'h4
    } scfg_state_t;
endpackage

// >>> src/scfg_if.sv
`timescale 1ns/1ns
`default_nettype none
interface scfg_if;
    logic sclk;               // Serial clock, host made
    logic frame_enable_n;     // Frame enable, active low
    logic host_sdio_o;        // Host drive value
    logic host_sdio_oe;       // Host drives data pin
    logic dev_sdio_o;         // Device drive value
    logic dev_sdio_oe;        // Device drives data pin
    logic sdo_o;              // Device output value
    logic sdo_oe;             // Device drives output pin
    logic sdio;               // Resolved data pin level
    logic serial_data_output; // Resolved output pin
    // Undriven pins float high, as with a pull-up
    assign sdio = dev_sdio_oe ? dev_sdio_o
                : (host_sdio_oe ? host_sdio_o : 1'h1);
    assign serial_data_output = sdo_oe ? sdo_o : 1'h1;
    modport dev (
        input  sclk, frame_enable_n, sdio,
        output dev_sdio_o, dev_sdio_oe, sdo_o, sdo_oe
    );
    modport host (
        output sclk, frame_enable_n, host_sdio_o,
        output host_sdio_oe,
        input  sdio, serial_data_output
    );
endinterface
`default_nettype wire

// >>> src/scfg_sync.sv
`timescale 1ns/1ns
`default_nettype none
module scfg_sync #(
    parameter int WIDTH = 2 // Bits to bring across
) (
    input  wire logic             clk, // System clock
    input  wire logic             rst, // Async reset
    input  wire logic [WIDTH-1:0] d,   // Foreign levels
    output logic      [WIDTH-1:0] q    // Safe levels
);
    logic [WIDTH-1:0] meta_ff; // First stage, read by q_ff only
    logic [WIDTH-1:0] q_ff;    // Second stage

    // Two stages against metastability
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            meta_ff <= '0;
            q_ff    <= '0;
        end
        else
        begin
            meta_ff <= d;
            q_ff    <= meta_ff;
        end
    end

    assign q = q_ff;
endmodule
`default_nettype wire

// >>> src/scfg_dev.sv
`timescale 1ns/1ns
`default_nettype none
module scfg_dev
    import scfg_pkg::*;
(
    input  wire logic         rst,              // Async reset
    scfg_if.dev               link,             // Serial pins
    output logic [DATA_W-1:0] datapath_control, // Control word
    output logic              four_wire_select  // Pin mode
);
    // The whole device runs on the host's serial clock.
    // That clock stops between frames, so nothing here
    // may wait for an edge outside a frame: frame state
    // is cleared by the enable itself, asynchronously.

    // Frame bookkeeping
    logic              frame_rst;   // Enable high or reset
    logic [4:0]        cnt_ff;      // Rising edges so far
    logic [4:0]        nxt_cnt;     // Saturating increment
    logic              cnt_done;    // All bits received
    logic [DATA_W-1:0] sh_ff;       // Input shift register
    logic [DATA_W-1:0] nxt_sh;      // Shift with new bit
    logic              rw_ff;       // Frame is a read
    logic [IDX_W-1:0]  idx_ff;      // Addressed register
    logic              instr_end;   // Last instruction bit
    logic              data_end;    // Last data bit

    // Register file
    logic [DATA_W-1:0] ctrl_ff;     // Datapath control
    logic              four_ff;     // Four-wire select
    logic              commit;      // Whole write arrived
    logic              wr_ctrl;     // Write control word
    logic              wr_mode;     // Write port mode
    logic [DATA_W-1:0] mode_word;   // Port mode readback
    logic [DATA_W-1:0] rd_word;     // Selected read word

    // Read launch
    logic              rd_active;   // Read bit window
    logic              rd_tail;     // After last read bit
    logic [3:0]        rd_pos;      // Bit of word to send
    logic              rd_bit;      // Bit to launch
    logic              sdio_o_ff;   // Data pin value
    logic              sdio_oe_ff;  // Data pin enable
    logic              sdo_o_ff;    // Output pin value
    logic              sdo_oe_ff;   // Output pin enable

    assign frame_rst = rst | link.frame_enable_n;

    // Count saturates, so extra clocks do nothing
    assign cnt_done = (cnt_ff == FRAME_BITS);
    assign nxt_cnt  = cnt_done ? cnt_ff : cnt_ff + 5'h01;

    // newest bit enters at the bottom
    assign nxt_sh = {sh_ff[DATA_W-2:0], link.sdio};

    // Phase markers, valid at the rising edge
    assign instr_end = (cnt_ff == INSTR_BITS - 5'h01);
    assign data_end  = (cnt_ff == LAST_BIT);

    // only a full sixteenth bit commits
    assign commit  = data_end & ~rw_ff;
    assign wr_ctrl = commit & (idx_ff == IDX_DATAPATH);
    assign wr_mode = commit & (idx_ff == IDX_PORT_MODE);

    // Port mode word carries the single mode bit
    assign mode_word = DATA_W'(four_ff) << FOUR_WIRE_POS;

    // index selects readback, others read zero
    assign rd_word = (idx_ff == IDX_DATAPATH)  ? ctrl_ff
                   : (idx_ff == IDX_PORT_MODE) ? mode_word
                   : 16'h0;

    // Falling-edge view of the count
    assign rd_active = rw_ff & (cnt_ff >= INSTR_BITS)
                     & (cnt_ff <= LAST_BIT);
    assign rd_tail   = rw_ff & cnt_done;

    // first data bit is bit fifteen
    assign rd_pos = 4'(LAST_BIT - cnt_ff);
    assign rd_bit = rd_word[rd_pos];

    always_ff @(posedge link.sclk or posedge frame_rst)
    begin
        if (frame_rst)
            cnt_ff <= 5'h0;
        else
            cnt_ff <= nxt_cnt;
    end

    always_ff @(posedge link.sclk or posedge frame_rst)
    begin
        if (frame_rst)
            sh_ff <= 16'h0;
        else if (~cnt_done)
            sh_ff <= nxt_sh;
    end

    always_ff @(posedge link.sclk or posedge frame_rst)
    begin
        if (frame_rst)
        begin
            rw_ff  <= 1'h0;
            idx_ff <= 7'h0;
        end
        else if (instr_end)
        begin
            rw_ff  <= nxt_sh[RW_POS];
            idx_ff <= nxt_sh[IDX_W-1:0];
        end
    end

    // control word written on full frame
    always_ff @(posedge link.sclk or posedge rst)
    begin
        if (rst)
            ctrl_ff <= DATAPATH_RST;
        else if (wr_ctrl)
            ctrl_ff <= nxt_sh;
    end

    // mode bit in its own register
    always_ff @(posedge link.sclk or posedge rst)
    begin
        if (rst)
            four_ff <= 1'h0;
        else if (wr_mode)
            four_ff <= nxt_sh[FOUR_WIRE_POS];
    end

    // read bits change on falling edge.
    // Ending the frame clears the enables at once,
    // which is how both pins return to high impedance.
    always_ff @(negedge link.sclk or posedge frame_rst)
    begin
        if (frame_rst)
        begin
            sdio_o_ff  <= 1'h0;
            sdio_oe_ff <= 1'h0;
            sdo_o_ff   <= 1'h0;
            sdo_oe_ff  <= 1'h0;
        end
        else if (rd_active)
        begin
            sdio_o_ff  <= rd_bit;
            sdio_oe_ff <= ~four_ff;
            sdo_o_ff   <= rd_bit;
            sdo_oe_ff  <= four_ff;
        end
        else if (rd_tail)
        begin
            // both pins low until frame ends
            sdio_o_ff  <= 1'h0;
            sdio_oe_ff <= 1'h1;
            sdo_o_ff   <= 1'h0;
            sdo_oe_ff  <= 1'h1;
        end
    end

    // Pins and user outputs straight from flops
    assign link.dev_sdio_o  = sdio_o_ff;
    assign link.dev_sdio_oe = sdio_oe_ff;
    assign link.sdo_o       = sdo_o_ff;
    assign link.sdo_oe      = sdo_oe_ff;
    assign datapath_control = ctrl_ff;
    assign four_wire_select = four_ff;
endmodule
`default_nettype wire

// >>> test/scfg_sva.sv
`timescale 1ns/1ns
`default_nettype none
module scfg_sva (
    input wire logic        clk,              // System clock
    input wire logic        rst,              // Async reset
    input wire logic        sclk,             // Serial clock
    input wire logic        frame_enable_n,   // Frame, active low
    input wire logic        host_sdio_oe,     // Host drives pin
    input wire logic        sdio,             // Data pin level
    input wire logic        dev_sdio_o,       // Device pin value
    input wire logic        dev_sdio_oe,      // Device drives pin
    input wire logic        sdo_o,            // Output pin value
    input wire logic        sdo_oe,           // Output pin enable
    input wire logic [15:0] datapath_control, // Control word
    input wire logic        four_wire_select  // Pin mode
);
    logic [4:0] cnt_ff; // Rising edges this frame
    logic       rw_ff;  // Direction of frame

    // Count rises; frame end clears it, as in the device
    always_ff @(posedge sclk or posedge rst or posedge frame_enable_n)
    begin
        if (rst || frame_enable_n)
            cnt_ff <= 5'h00;
        else if (cnt_ff != 5'h1f)
            cnt_ff <= cnt_ff + 5'h01;
    end

    // Keep the first bit of each frame
    always_ff @(posedge sclk or posedge rst)
    begin
        if (rst)
            rw_ff <= 1'h0;
        else if (cnt_ff == 5'h00)
            rw_ff <= sdio;
    end

    property p_idle_quiet;
        @(posedge clk) disable iff (rst)
        frame_enable_n |-> !dev_sdio_oe && !sdo_oe;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("device drives outside a frame");

    property p_instr_host;
        @(posedge clk) disable iff (rst)
        !frame_enable_n && cnt_ff < 5'h08 |-> host_sdio_oe && !dev_sdio_oe;
    endproperty
    a_instr_host: assert property (p_instr_host)
        else $error("data pin not host driven in instruction");

    property p_three_wire;
        @(posedge sclk) disable iff (rst)
        rw_ff && !four_wire_select && cnt_ff >= 5'h08 && cnt_ff <= 5'h17
        |-> dev_sdio_oe && !sdo_oe;
    endproperty
    a_three_wire: assert property (p_three_wire)
        else $error("three wire read on wrong pin");

    property p_four_wire;
        @(posedge sclk) disable iff (rst)
        rw_ff && four_wire_select && cnt_ff >= 5'h08 && cnt_ff <= 5'h17
        |-> sdo_oe && !dev_sdio_oe;
    endproperty
    a_four_wire: assert property (p_four_wire)
        else $error("four wire read on wrong pin");

    property p_tail_low;
        @(posedge clk) disable iff (rst)
        !frame_enable_n && rw_ff && cnt_ff == 5'h18 && !sclk
        |-> dev_sdio_oe && sdo_oe && !dev_sdio_o && !sdo_o;
    endproperty
    a_tail_low: assert property (p_tail_low)
        else $error("pins not low after last read bit");

    property p_fall_launch;
        @(posedge clk) disable iff (rst)
        sclk && !frame_enable_n
        |-> $stable(dev_sdio_o) && $stable(sdo_o);
    endproperty
    a_fall_launch: assert property (p_fall_launch)
        else $error("read bit changed while clock high");

    property p_frame_len;
        @(posedge clk) disable iff (rst)
        $rose(frame_enable_n) |-> $past(cnt_ff) == 5'h18;
    endproperty
    a_frame_len: assert property (p_frame_len)
        else $error("frame length not 24 clocks");

    property p_commit;
        @(posedge sclk) disable iff (rst)
        cnt_ff != 5'h17 |=> $stable(datapath_control);
    endproperty
    a_commit: assert property (p_commit)
        else $error("control word changed off the last bit");

    property p_write_quiet;
        @(posedge sclk) disable iff (rst)
        cnt_ff != 5'h00 && !rw_ff |-> !dev_sdio_oe && !sdo_oe;
    endproperty
    a_write_quiet: assert property (p_write_quiet)
        else $error("device drives in a write frame");

    c_rd3: cover property (@(posedge sclk) dev_sdio_oe && !four_wire_select);
    c_rd4: cover property (@(posedge sclk) sdo_oe && four_wire_select);
    c_wr: cover property (@(posedge sclk) cnt_ff == 5'h17 && !rw_ff);
endmodule
`default_nettype wire

// >>> test/tb_serial_config_port.sv
`timescale 1ns/1ns
`default_nettype none
module tb_serial_config_port
    import scfg_pkg::*;
;
    logic        clk, rst;                       // Clock, reset
    logic [3:0]  awaddr, araddr, wstrb;          // Bus addresses, byte enables
    logic [31:0] wdata, rdata, d;                // Bus data
    logic        awvalid, wvalid, bready;        // Write requests
    logic        arvalid, rready;                // Read requests
    logic        awready, wready, bvalid;        // Write answers
    logic        arready, rvalid;                // Read answers
    logic [1:0]  bresp, rresp, r;                // Responses
    logic [15:0] dpc, dpc2;                      // Control words
    logic        fws;                            // Pin mode
    int          errors, checked;                // Tallies

    scfg_if link ();
    scfg_if link2 ();
    // Small divider keeps frames short
    scfg_host #(.SCLK_HALF(2)) scfg_host_i (
        .clk(clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .link(link));
    scfg_dev scfg_dev_i (.rst(rst), .link(link),
        .datapath_control(dpc), .four_wire_select(fws));
    // Second device, fed by a rule-breaking driver
    scfg_dev scfg_dev_abort_i (.rst(rst), .link(link2),
        .datapath_control(dpc2), .four_wire_select());
    scfg_sva scfg_sva_i (.clk(clk), .rst(rst), .sclk(link.sclk),
        .frame_enable_n(link.frame_enable_n),
        .host_sdio_oe(link.host_sdio_oe), .sdio(link.sdio),
        .dev_sdio_o(link.dev_sdio_o), .dev_sdio_oe(link.dev_sdio_oe),
        .sdo_o(link.sdo_o), .sdo_oe(link.sdo_oe),
        .datapath_control(dpc), .four_wire_select(fws));

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task chk(input string nm, input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Bus write; holds each valid until its own ready
    task wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask

    // Bus read
    task rd(input logic [3:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    // Poll busy, bounded
    task idle();
        for (int n = 0; n < 200; n++)
        begin
            rd(OFS_STATUS);
            if (d[0] === 1'b0) break;
        end
        chk("busy", {31'h0, d[0]}, 32'h0);
    endtask

    task frame(input logic [8:0] cmd, input logic [15:0] v);
        wr(OFS_WDATA, {16'h0, v});
        wr(OFS_CMD, {23'h0, cmd});
        idle();
    endtask

    task ser_rd(input logic [8:0] cmd, input logic [15:0] exp);
        frame(cmd, 16'h0);
        rd(OFS_RDATA);
        chk("serial read", d, {16'h0, exp});
    endtask

    // Drive n bits MSB first at a 15 ns link period
    task raw(input logic [23:0] v, input int n);
        #3 link2.frame_enable_n = 1'b0;
        link2.host_sdio_oe = 1'b1;
        for (int i = 0; i < n; i++)
        begin
            link2.host_sdio_o = v[23-i];
            #7 link2.sclk = 1'b1;
            #8 link2.sclk = 1'b0;
        end
        #8 link2.frame_enable_n = 1'b1;
        link2.host_sdio_oe = 1'b0;
    endtask

    task stop_test();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Hang guard, far beyond the expected run
    initial
    begin
        #(30000 * 50);
        errors++;
        stop_test();
    end

    initial
    begin
        {awaddr, araddr, wdata, awvalid, wvalid, bready} = '0;
        {arvalid, rready} = '0;
        wstrb = 4'hf;
        {link2.sclk, link2.host_sdio_o, link2.host_sdio_oe} = '0;
        link2.frame_enable_n = 1'b1;
        rst = 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        chk("reset word", {16'h0, dpc}, {16'h0, DATAPATH_RST});
        chk("reset mode", {31'h0, fws}, 32'h0);
        ser_rd(9'h080, DATAPATH_RST);
        frame(9'h000, 16'ha5c3);
        chk("write word", {16'h0, dpc}, 32'ha5c3);
        ser_rd(9'h080, 16'ha5c3);
        frame(9'h005, 16'hffff);
        chk("other index", {16'h0, dpc}, 32'ha5c3);
        ser_rd(9'h085, 16'h0000);
        frame(9'h002, 16'h0080);
        chk("four wire", {31'h0, fws}, 32'h1);
        ser_rd(9'h180, 16'ha5c3);
        ser_rd(9'h182, 16'h0080);
        frame(9'h002, 16'h0000);
        chk("three wire", {31'h0, fws}, 32'h0);
        // Second command lands while the first frame runs
        wr(OFS_WDATA, 32'h0f0f);
        wr(OFS_CMD, 32'h0);
        wr(OFS_CMD, 32'h85);
        chk("busy resp", {30'h0, r}, {30'h0, RESP_OKAY});
        rd(OFS_CMD);
        chk("cmd kept", d, 32'h0);
        rd(OFS_WDATA);
        chk("wdata kept", d, 32'h0f0f);
        idle();
        chk("busy word", {16'h0, dpc}, 32'h0f0f);
        wr(4'h2, 32'h1);
        chk("bad wr", {30'h0, r}, {30'h0, RESP_SLVERR});
        rd(4'h2);
        chk("bad rd", {30'h0, r}, {30'h0, RESP_SLVERR});
        raw(24'h001234, 20);
        chk("short write", {16'h0, dpc2}, {16'h0, DATAPATH_RST});
        raw(24'h001234, 24);
        chk("raw write", {16'h0, dpc2}, 32'h1234);
        stop_test();
    end
endmodule
`default_nettype wire
